//--- rtl/four_bit_branch_skip_decoder.sv
// Purpose: Branch, call, return, skip and control-transfer execution for a 4-bit core
// Assumes: rom_data and mem_nibble are valid combinationally for rom_addr and data_pointer
// Notes:   Other instruction groups act as one-cycle no-ops; their results arrive on upd_*
// Overview of operation
// - Skip next if accumulator equals memory nibble
// - Skip next if accumulator equals immediate
// - Near jump replaces only the page offset
// - Far jump loads page and offset
// - Indirect far jump offset is D and accumulator
// - Near call pushes, jumps into page two
// - Far call pushes, loads page and offset
// - Indirect far call pushes, offset D and accumulator
// - Interrupt return pops saved program counter
// - Interrupt return restores the saved core context
// - Plain return pops, no skip
// - Skip return pops then skips unconditionally
// - Request test skips on flag and clears it, if select bit is clear
// - Pin test skips on pin matching polarity
// - Disable and enable set interrupt enable
// - Interrupt control registers transfer with accumulator
// - Prescaler write takes accumulator bit zero
// - Five timer controls transfer with accumulator
`timescale 1ns/1ns
module four_bit_branch_skip_decoder
  import decoder_pkg::*;
#(
  parameter int              STACK_DEPTH = 8,
  parameter logic [PC_W-1:0] IRQ_VECTOR  = 14'h0000
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [PC_W-1:0]   rom_addr,
  input  wire logic [WORD_W-1:0] rom_data,
  input  wire logic [NIB_W-1:0]  mem_nibble,
  output logic      [PTR_W-1:0]  data_pointer,
  output logic      [NIB_W-1:0]  acc,
  output logic                   inte,
  input  wire logic              int_pin,
  input  wire logic              ext_req_set,
  input  wire logic              irq_req,
  output logic                   irq_ack,
  input  wire logic              upd_valid,
  input  wire logic [NIB_W-1:0]  upd_acc,
  input  wire logic [NIB_W-1:0]  upd_b,
  input  wire logic [D_W-1:0]    upd_d,
  input  wire logic [PTR_W-1:0]  upd_pointer,
  input  wire logic              upd_carry,
  input  wire logic              upd_load_nop
);
  phase_t                      phase, next_phase;
  logic [WORD_W-1:0]           first_word, next_first_word;
  logic [PC_W-1:0]             pc, next_pc, pc_inc, stack_top;
  logic [NIB_W-1:0]            next_acc, reg_b, next_reg_b;
  logic [D_W-1:0]              reg_d, next_reg_d;
  logic [PTR_W-1:0]            next_data_pointer;
  logic                        carry_flag, next_carry_flag, load_nop, next_load_nop;
  logic                        skip, next_skip, next_inte;
  logic                        ext_request_flag, next_ext_request_flag;
  logic [NIB_W-1:0]            irq_ctrl_a, next_irq_ctrl_a, irq_ctrl_b, next_irq_ctrl_b;
  logic [NIB_W-1:0]            ext_irq_ctrl, next_ext_irq_ctrl;
  logic                        prescaler_ctrl, next_prescaler_ctrl;
  logic [TMR_N-1:0][NIB_W-1:0] timer_ctrl, next_timer_ctrl;
  logic                        stack_push, stack_pop, ctx_store, ctx_restore, ctx_held;
  logic [PC_W-1:0]             push_value;
  logic [CTX_W-1:0]            ctx_now, ctx_saved;
  logic                        exec, pin_hit;
  logic [2:0]                  tmr_idx;
  logic                        run, next_run, rd_done, next_rd_done, addr_hit;
  logic [31:0]                 next_prdata, rd_mux;

  generate
    if (STACK_DEPTH < 2) begin : g_bad_stack
      $error("STACK_DEPTH must be at least 2");
    end
  endgenerate

  assign pc_inc   = pc + PC_W'(1);
  assign rom_addr = pc;
  assign exec     = ce && run && phase == ST_FETCH && !skip;
  assign pin_hit  = ext_irq_ctrl[PIN_POLARITY_BIT] ? int_pin : !int_pin;
  assign ctx_now  = {data_pointer, carry_flag, skip, load_nop, acc, reg_b};

  ret_stack #(.WIDTH(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .push      (stack_push),
    .pop       (stack_pop),
    .push_data (push_value),
    .top_data  (stack_top)
  );

  ctx_save #(.WIDTH(CTX_W)) u_ctx (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .save         (ctx_store),
    .release_slot (ctx_restore),
    .ctx_in       (ctx_now),
    .ctx_out      (ctx_saved),
    .held         (ctx_held)
  );

  always_comb begin
    next_phase = phase;  next_first_word = first_word;  next_pc = pc;
    next_acc = acc;  next_reg_b = reg_b;  next_reg_d = reg_d;
    next_data_pointer = data_pointer;  next_carry_flag = carry_flag;
    next_load_nop = load_nop;  next_skip = skip;  next_inte = inte;
    next_ext_request_flag = ext_request_flag;
    next_irq_ctrl_a = irq_ctrl_a;  next_irq_ctrl_b = irq_ctrl_b;
    next_ext_irq_ctrl = ext_irq_ctrl;  next_prescaler_ctrl = prescaler_ctrl;
    next_timer_ctrl = timer_ctrl;
    stack_push = 1'b0;  stack_pop = 1'b0;  push_value = pc_inc;
    ctx_store = 1'b0;  ctx_restore = 1'b0;  irq_ack = 1'b0;
    tmr_idx = 3'(rom_data - OP_TIMER_READ_FIRST);
    if (ce) begin
      // Results of the other instruction groups; local execution below overrides
      if (upd_valid) begin
        next_acc = upd_acc;  next_reg_b = upd_b;  next_reg_d = upd_d;
        next_data_pointer = upd_pointer;
        next_carry_flag = upd_carry;  next_load_nop = upd_load_nop;
      end
      if (run && phase == ST_FETCH && skip) begin
        next_skip = 1'b0;
        next_pc   = pc_inc;
      end else if (exec && irq_req && inte) begin
        // Taken only between whole instructions, so an operand word is never split
        stack_push = 1'b1;
        push_value = pc;
        ctx_store  = 1'b1;
        next_inte  = 1'b0;
        next_pc    = IRQ_VECTOR;
        irq_ack    = 1'b1;
      end else if (exec) begin
        next_pc = pc_inc;
        if (rom_data[9:7] == PFX_NEAR_JUMP) begin
          next_pc = {pc[PC_W-1:OFFS_W], rom_data[OFFS_W-1:0]};
        end else if (rom_data[9:7] == PFX_NEAR_CALL) begin
          stack_push = 1'b1;
          next_pc    = {SUB_PAGE, rom_data[OFFS_W-1:0]};
        end else if (rom_data[9:5] == PFX_FAR_JUMP || rom_data[9:5] == PFX_FAR_CALL ||
                     rom_data == OP_FAR_JUMP_INDIRECT || rom_data == OP_FAR_CALL_INDIRECT ||
                     rom_data == OP_CMP_ACC_IMM_SKIP) begin
          next_first_word = rom_data;
          next_phase      = ST_OPERAND;
        end else if (rom_data >= OP_TIMER_READ_FIRST && rom_data <= OP_TIMER_READ_LAST) begin
          next_acc = timer_ctrl[tmr_idx];
        end else if (rom_data >= OP_TIMER_WRITE_FIRST && rom_data <= OP_TIMER_WRITE_LAST) begin
          tmr_idx = 3'(rom_data - OP_TIMER_WRITE_FIRST);
          next_timer_ctrl[tmr_idx] = acc;
        end else begin
          case (rom_data)
            OP_CMP_ACC_MEM_SKIP:   next_skip = (acc == mem_nibble);
            OP_RETURN: begin
              stack_pop = 1'b1;
              next_pc   = stack_top;
            end
            OP_RETURN_SKIP: begin
              stack_pop = 1'b1;
              next_pc   = stack_top;
              next_skip = 1'b1;
            end
            OP_RETURN_FROM_IRQ: begin
              stack_pop   = 1'b1;
              next_pc     = stack_top;
              ctx_restore = 1'b1;
              {next_data_pointer, next_carry_flag, next_skip, next_load_nop,
               next_acc, next_reg_b} = ctx_saved;
            end
            OP_IRQ_DISABLE:        next_inte = 1'b0;
            OP_IRQ_ENABLE:         next_inte = 1'b1;
            OP_EXT_REQUEST_TEST: begin
              if (!irq_ctrl_a[EXT_REQUEST_SELECT_BIT]) begin
                next_skip             = ext_request_flag;
                next_ext_request_flag = 1'b0;
              end
            end
            OP_EXT_PIN_LEVEL_TEST: next_skip = pin_hit;
            OP_READ_CTRL_A:        next_acc = irq_ctrl_a;
            OP_WRITE_CTRL_A:       next_irq_ctrl_a = acc;
            OP_READ_CTRL_B:        next_acc = irq_ctrl_b;
            OP_WRITE_CTRL_B:       next_irq_ctrl_b = acc;
            OP_READ_EXT_CTRL:      next_acc = ext_irq_ctrl;
            OP_WRITE_EXT_CTRL:     next_ext_irq_ctrl = acc;
            OP_PRESCALER_WRITE:    next_prescaler_ctrl = acc[0];
            default: ;
          endcase
        end
      end else if (run && phase == ST_OPERAND) begin
        next_phase = ST_FETCH;
        next_pc    = pc_inc;
        if (first_word == OP_CMP_ACC_IMM_SKIP) begin
          next_skip = (acc == rom_data[NIB_W-1:0]);
        end else if (first_word == OP_FAR_JUMP_INDIRECT || first_word == OP_FAR_CALL_INDIRECT) begin
          stack_push = (first_word == OP_FAR_CALL_INDIRECT);
          next_pc    = {rom_data[8:6], rom_data[3:0], reg_d, acc};
        end else begin
          stack_push = (first_word[9:5] == PFX_FAR_CALL);
          next_pc    = {rom_data[8:7], first_word[4:0], rom_data[OFFS_W-1:0]};
        end
      end
      // A request arriving with the test's clear is kept
      if (ext_req_set) begin
        next_ext_request_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= ST_FETCH;  first_word <= '0;  pc <= RST_PC;
      acc <= RST_NIB;  reg_b <= RST_NIB;  reg_d <= '0;  data_pointer <= RST_PTR;
      carry_flag <= 1'b0;  load_nop <= 1'b0;  skip <= 1'b0;  inte <= 1'b0;
      ext_request_flag <= 1'b0;  irq_ctrl_a <= RST_NIB;  irq_ctrl_b <= RST_NIB;
      ext_irq_ctrl <= RST_NIB;  prescaler_ctrl <= 1'b0;  timer_ctrl <= '0;
    end else begin
      phase <= next_phase;  first_word <= next_first_word;  pc <= next_pc;
      acc <= next_acc;  reg_b <= next_reg_b;  reg_d <= next_reg_d;
      data_pointer <= next_data_pointer;
      carry_flag <= next_carry_flag;  load_nop <= next_load_nop;
      skip <= next_skip;  inte <= next_inte;
      ext_request_flag <= next_ext_request_flag;
      irq_ctrl_a <= next_irq_ctrl_a;  irq_ctrl_b <= next_irq_ctrl_b;
      ext_irq_ctrl <= next_ext_irq_ctrl;  prescaler_ctrl <= next_prescaler_ctrl;
      timer_ctrl <= next_timer_ctrl;
    end
  end

  // APB slave: read data is captured one cycle ahead so that prdata comes from a flop
  assign addr_hit = paddr == REG_CTRL || paddr == REG_PC || paddr == REG_CORE ||
                    paddr == REG_IRQ || paddr == REG_TIMER;
  assign pready   = ce && psel && penable && rd_done;
  assign pslverr  = pready && !addr_hit;

  always_comb begin
    case (paddr)
      REG_CTRL:  rd_mux = {31'h0, run};
      REG_PC:    rd_mux = {18'h0, pc};
      REG_CORE:  rd_mux = {2'h0, data_pointer, 3'h0, phase, ext_request_flag, inte, load_nop,
                           skip, carry_flag, reg_d, reg_b, acc};
      REG_IRQ:   rd_mux = {19'h0, prescaler_ctrl, ext_irq_ctrl, irq_ctrl_b, irq_ctrl_a};
      REG_TIMER: rd_mux = {12'h0, timer_ctrl};
      default:   rd_mux = 32'h0;
    endcase
    next_prdata  = prdata;
    next_rd_done = rd_done;
    next_run     = run;
    if (ce && psel && !rd_done) begin
      next_prdata  = pwrite ? 32'h0 : rd_mux;
      next_rd_done = 1'b1;
    end
    if (pready) begin
      next_rd_done = 1'b0;
      if (pwrite && paddr == REG_CTRL) begin
        next_run = pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      rd_done <= 1'b0;
      run     <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      rd_done <= next_rd_done;
      run     <= next_run;
    end
  end

  property p_cmp_mem;
    @(posedge pclk) disable iff (!presetn)
      exec && !irq_req && rom_data == OP_CMP_ACC_MEM_SKIP |=> skip == $past(acc == mem_nibble);
  endproperty
  a_cmp_mem: assert property (p_cmp_mem) else $error("memory compare skip wrong");

  property p_cmp_imm;
    @(posedge pclk) disable iff (!presetn)
      ce && run && phase == ST_OPERAND && first_word == OP_CMP_ACC_IMM_SKIP
      |=> skip == $past(acc == rom_data[NIB_W-1:0]) && phase == ST_FETCH;
  endproperty
  a_cmp_imm: assert property (p_cmp_imm) else $error("immediate compare skip wrong");

  property p_near_jump;
    @(posedge pclk) disable iff (!presetn)
      exec && !(irq_req && inte) && rom_data[9:7] == PFX_NEAR_JUMP
      |=> pc == {$past(pc[PC_W-1:OFFS_W]), $past(rom_data[OFFS_W-1:0])};
  endproperty
  a_near_jump: assert property (p_near_jump) else $error("near jump changed page");

  property p_near_call;
    @(posedge pclk) disable iff (!presetn)
      exec && !(irq_req && inte) && rom_data[9:7] == PFX_NEAR_CALL
      |=> pc[PC_W-1:OFFS_W] == SUB_PAGE && stack_top == $past(pc_inc);
  endproperty
  a_near_call: assert property (p_near_call) else $error("near call target or push wrong");

  property p_return_skip;
    @(posedge pclk) disable iff (!presetn)
      exec && !(irq_req && inte) && rom_data == OP_RETURN_SKIP
      |=> skip && pc == $past(stack_top) ##1 (!ce || (!skip && pc == $past(pc) + PC_W'(1)));
  endproperty
  a_return_skip: assert property (p_return_skip) else $error("skip return did not skip");

  property p_return_irq;
    @(posedge pclk) disable iff (!presetn)
      exec && !(irq_req && inte) && rom_data == OP_RETURN_FROM_IRQ
      |=> pc == $past(stack_top) && acc == $past(ctx_saved[2*NIB_W-1:NIB_W]) && !ctx_held;
  endproperty
  a_return_irq: assert property (p_return_irq) else $error("interrupt return restore wrong");

  property p_req_test;
    @(posedge pclk) disable iff (!presetn)
      exec && !(irq_req && inte) && rom_data == OP_EXT_REQUEST_TEST &&
      !irq_ctrl_a[EXT_REQUEST_SELECT_BIT] && ext_request_flag && !ext_req_set
      |=> skip && !ext_request_flag;
  endproperty
  a_req_test: assert property (p_req_test) else $error("request test did not skip and clear");

  property p_pin_test;
    @(posedge pclk) disable iff (!presetn)
      exec && !(irq_req && inte) && rom_data == OP_EXT_PIN_LEVEL_TEST
      |=> skip == $past(int_pin == ext_irq_ctrl[PIN_POLARITY_BIT]);
  endproperty
  a_pin_test: assert property (p_pin_test) else $error("pin level test wrong");

  property p_prescaler;
    @(posedge pclk) disable iff (!presetn)
      exec && !(irq_req && inte) && rom_data == OP_PRESCALER_WRITE
      |=> prescaler_ctrl == $past(acc[0]) && phase == ST_FETCH;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("prescaler write wrong");

  property p_skip_advance;
    @(posedge pclk) disable iff (!presetn)
      ce && run && phase == ST_FETCH && skip |=> !skip && pc == $past(pc_inc) && phase == ST_FETCH;
  endproperty
  a_skip_advance: assert property (p_skip_advance) else $error("skipped word not passed over");
endmodule

//--- shared/decoder_pkg.sv
// Purpose: Shared constants for the branch, skip and control-transfer decoder
// Assumes: 10-bit program words, 4-bit data path, 32-bit APB register bus
// Notes:   Register offsets are byte addresses
package decoder_pkg;
  localparam int WORD_W = 10;
  localparam int PAGE_W = 7;
  localparam int OFFS_W = 7;
  localparam int PC_W   = 14;
  localparam int NIB_W  = 4;
  localparam int D_W    = 3;
  localparam int PTR_W  = 10;
  localparam int TMR_N  = 5;
  localparam int CTX_W  = PTR_W + 3 + 2 * NIB_W;
  localparam int ADDR_W = 8;

  localparam logic [WORD_W-1:0] OP_CMP_ACC_MEM_SKIP   = 10'h026;
  localparam logic [WORD_W-1:0] OP_CMP_ACC_IMM_SKIP   = 10'h025;
  localparam logic [WORD_W-1:0] OP_FAR_JUMP_INDIRECT  = 10'h010;
  localparam logic [WORD_W-1:0] OP_FAR_CALL_INDIRECT  = 10'h030;
  localparam logic [WORD_W-1:0] OP_RETURN_FROM_IRQ    = 10'h046;
  localparam logic [WORD_W-1:0] OP_RETURN             = 10'h044;
  localparam logic [WORD_W-1:0] OP_RETURN_SKIP        = 10'h045;
  localparam logic [WORD_W-1:0] OP_IRQ_DISABLE        = 10'h004;
  localparam logic [WORD_W-1:0] OP_IRQ_ENABLE         = 10'h005;
  localparam logic [WORD_W-1:0] OP_EXT_REQUEST_TEST   = 10'h038;
  localparam logic [WORD_W-1:0] OP_EXT_PIN_LEVEL_TEST = 10'h03a;
  localparam logic [WORD_W-1:0] OP_READ_CTRL_A        = 10'h054;
  localparam logic [WORD_W-1:0] OP_WRITE_CTRL_A       = 10'h03f;
  localparam logic [WORD_W-1:0] OP_READ_CTRL_B        = 10'h055;
  localparam logic [WORD_W-1:0] OP_WRITE_CTRL_B       = 10'h03e;
  localparam logic [WORD_W-1:0] OP_READ_EXT_CTRL      = 10'h253;
  localparam logic [WORD_W-1:0] OP_WRITE_EXT_CTRL     = 10'h217;
  localparam logic [WORD_W-1:0] OP_PRESCALER_WRITE    = 10'h2aa;
  localparam logic [WORD_W-1:0] OP_TIMER_READ_FIRST   = 10'h24b;
  localparam logic [WORD_W-1:0] OP_TIMER_READ_LAST    = 10'h24f;
  localparam logic [WORD_W-1:0] OP_TIMER_WRITE_FIRST  = 10'h20e;
  localparam logic [WORD_W-1:0] OP_TIMER_WRITE_LAST   = 10'h212;

  // Prefix fields: bits 9:7 for near forms, 9:5 for far forms
  localparam logic [2:0] PFX_NEAR_JUMP = 3'h3;
  localparam logic [2:0] PFX_NEAR_CALL = 3'h2;
  localparam logic [4:0] PFX_FAR_JUMP  = 5'h07;
  localparam logic [4:0] PFX_FAR_CALL  = 5'h06;

  localparam logic [PAGE_W-1:0] SUB_PAGE = 7'h02;
  localparam int EXT_REQUEST_SELECT_BIT = 0;
  localparam int PIN_POLARITY_BIT       = 2;

  localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PC    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CORE  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ   = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_TIMER = 8'h10;

  localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
  localparam logic [PC_W-1:0]  RST_PC  = 14'h0000;
  localparam logic [PTR_W-1:0] RST_PTR = 10'h000;

  typedef enum logic [0:0] {
    ST_FETCH   = 1'b0,
    ST_OPERAND = 1'b1
  } phase_t;
endpackage

//--- rtl/ret_stack.sv
// Purpose: Return-address stack in flip-flops
// Assumes: Push and pop never in the same cycle
// Notes:   Overflow wraps and overwrites the oldest entry
`timescale 1ns/1ns
module ret_stack #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_data
);
  localparam int SP_W = $clog2(DEPTH);

  logic [SP_W-1:0]  sp;
  logic [SP_W-1:0]  next_sp;
  logic [WIDTH-1:0] entry [DEPTH];

  generate
    if (DEPTH < 2 || (1 << SP_W) != DEPTH) begin : g_bad_depth
      $error("ret_stack depth must be a power of two of at least 2");
    end
  endgenerate

  always_comb begin
    next_sp = sp;
    if (ce && push) begin
      next_sp = sp + SP_W'(1);
    end else if (ce && pop) begin
      next_sp = sp - SP_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= '0;
    end else begin
      sp <= next_sp;
    end
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      logic [WIDTH-1:0] next_entry;
      always_comb begin
        next_entry = entry[i];
        if (ce && push && next_sp == SP_W'(i)) begin
          next_entry = push_data;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          entry[i] <= '0;
        end else begin
          entry[i] <= next_entry;
        end
      end
    end
  endgenerate

  assign top_data = entry[sp];
endmodule

//--- rtl/ctx_save.sv
// Purpose: Holds the core context captured on interrupt entry
// Assumes: Nested interrupts are not taken, so one slot suffices
// Notes:   held shows whether the slot carries a live snapshot
`timescale 1ns/1ns
module ctx_save #(
  parameter int WIDTH = 21
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             save,
  input  wire logic             release_slot,
  input  wire logic [WIDTH-1:0] ctx_in,
  output logic      [WIDTH-1:0] ctx_out,
  output logic                  held
);
  logic [WIDTH-1:0] next_ctx;
  logic             next_held;

  always_comb begin
    next_ctx  = ctx_out;
    next_held = held;
    if (ce && save) begin
      next_ctx  = ctx_in;
      next_held = 1'b1;
    end else if (ce && release_slot) begin
      next_held = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_out <= '0;
      held    <= 1'b0;
    end else begin
      ctx_out <= next_ctx;
      held    <= next_held;
    end
  end
endmodule

//--- tb/prog_mem_model.sv
// Purpose: Program ROM and data memory beside the decoder
// Assumes: Asynchronous reads, valid in the cycle of the address
// Notes:   Bench fills image; nibble is the low pointer bits xor 5
`timescale 1ns/1ns
module prog_mem_model
  import decoder_pkg::*;
(
  input  wire logic [PC_W-1:0]   rom_addr,
  output logic      [WORD_W-1:0] rom_data,
  input  wire logic [PTR_W-1:0]  data_pointer,
  output logic      [NIB_W-1:0]  mem_nibble
);
  logic [WORD_W-1:0] image [0:511];
  assign rom_data   = (rom_addr < 14'h0200) ? image[rom_addr[8:0]] : 10'h000;
  assign mem_nibble = data_pointer[NIB_W-1:0] ^ 4'h5;
endmodule

//--- tb/tb_four_bit_branch_skip_decoder.sv
// Purpose: Self-checking bench for the branch and skip decoder
// Assumes: The interrupt pin stays low
// Notes:   Skipped words are disable ops, so a missed skip clears inte
`timescale 1ns/1ns
module tb_four_bit_branch_skip_decoder
  import decoder_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic upd_valid = 1'b0, upd_carry = 1'b0, upd_load_nop = 1'b0, ext_req_set = 1'b0, irq_req = 1'b0;
  logic pready, pslverr, inte, irq_ack, seen_err;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [PC_W-1:0] rom_addr;
  logic [WORD_W-1:0] rom_data;
  logic [NIB_W-1:0] mem_nibble, acc, upd_acc = 4'h0, upd_b = 4'h0;
  logic [D_W-1:0] upd_d = 3'h0;
  logic [PTR_W-1:0] data_pointer, upd_pointer = 10'h000;
  int bad_count = 0;
  int n_compared = 0;
  always #5 pclk = ~pclk;
  four_bit_branch_skip_decoder #(.IRQ_VECTOR(14'h01c8)) u_four_bit_branch_skip_decoder (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rom_addr(rom_addr), .rom_data(rom_data), .mem_nibble(mem_nibble), .data_pointer(data_pointer),
    .acc(acc), .inte(inte), .int_pin(1'b0), .ext_req_set(ext_req_set), .irq_req(irq_req), .irq_ack(irq_ack),
    .upd_valid(upd_valid), .upd_acc(upd_acc), .upd_b(upd_b), .upd_d(upd_d), .upd_pointer(upd_pointer),
    .upd_carry(upd_carry), .upd_load_nop(upd_load_nop));
  prog_mem_model u_prog_mem_model (.rom_addr(rom_addr), .rom_data(rom_data),
    .data_pointer(data_pointer), .mem_nibble(mem_nibble));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    // An idle edge first, so psel is never lowered and raised in one step
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
    // Nothing moves between this falling edge and the completing rising edge
    seen_err = pslverr;
    rd = prdata;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_branch_skip();
    int k;
    for (k = 0; k < 512; k++) u_prog_mem_model.image[k] = 10'h000;
    u_prog_mem_model.image[0] = OP_IRQ_ENABLE;
    u_prog_mem_model.image[1] = OP_CMP_ACC_MEM_SKIP;
    u_prog_mem_model.image[2] = OP_IRQ_DISABLE;
    u_prog_mem_model.image[3] = 10'h105;
    u_prog_mem_model.image[261] = OP_RETURN_SKIP;
    u_prog_mem_model.image[4] = OP_IRQ_DISABLE;
    u_prog_mem_model.image[5] = 10'h0e3;
    u_prog_mem_model.image[6] = 10'h210;
    u_prog_mem_model.image[400] = OP_CMP_ACC_IMM_SKIP;
    u_prog_mem_model.image[401] = 10'h075;
    u_prog_mem_model.image[402] = OP_IRQ_DISABLE;
    u_prog_mem_model.image[403] = 10'h193;
    upd_valid <= 1'b1;
    upd_acc <= 4'h5;
    upd_b <= 4'ha;
    @(posedge pclk);
    upd_valid <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h1);
    k = 0;
    while (rom_addr !== 14'h0193 && k < 60) begin
      @(negedge pclk);
      k++;
    end
    chk("reached loop", 32'h1, {31'h0, k < 60});
    if (k >= 60) give_verdict();
    chk("inte", 32'h1, {31'h0, inte});
    chk("acc", 32'h5, {28'h0, acc});
    @(posedge pclk);
    $display("test branch_skip done");
  endtask
  task automatic t_regs();
    apb(1'b0, REG_CORE, 32'h0);
    chk("core acc", 32'h5, {28'h0, rd[3:0]});
    chk("core b", 32'ha, {28'h0, rd[7:4]});
    chk("core inte", 32'h1, {31'h0, rd[14]});
    apb(1'b0, REG_PC, 32'h0);
    chk("pc", 32'h193, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, seen_err});
    chk("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask
  task automatic put(input int a, input logic [WORD_W-1:0] w);
    u_prog_mem_model.image[a] = w;
  endtask
  task automatic t_ctrl_ops();
    int k;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("reset pc", 32'h0, {18'h0, rom_addr});
    chk("reset acc", 32'h0, {28'h0, acc});
    presetn <= 1'b1;
    put(0, OP_IRQ_ENABLE);
    put(1, OP_EXT_REQUEST_TEST);
    put(2, OP_IRQ_DISABLE);
    put(3, OP_EXT_PIN_LEVEL_TEST);
    put(4, OP_IRQ_DISABLE);
    put(5, OP_WRITE_EXT_CTRL);
    put(6, OP_EXT_PIN_LEVEL_TEST);
    put(7, OP_TIMER_WRITE_FIRST);
    put(8, OP_PRESCALER_WRITE);
    put(9, OP_WRITE_CTRL_B);
    put(10, OP_EXT_REQUEST_TEST);
    put(11, OP_TIMER_WRITE_LAST);
    put(12, OP_FAR_CALL_INDIRECT);
    put(13, 10'h203);
    put(14, 10'h18e);
    put(429, OP_READ_CTRL_A);
    put(430, OP_RETURN);
    put(456, OP_READ_CTRL_B);
    put(457, OP_RETURN_FROM_IRQ);
    @(posedge pclk);
    upd_valid <= 1'b1;
    upd_acc <= 4'hd;
    upd_d <= 3'h2;
    ext_req_set <= 1'b1;
    @(posedge pclk);
    upd_valid <= 1'b0;
    ext_req_set <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h1);
    k = 0;
    while (rom_addr !== 14'h000e && k < 60) begin
      @(negedge pclk);
      k++;
    end
    if (k >= 60) begin
      bad_count++;
      give_verdict();
    end
    chk("ctrl inte", 32'h1, {31'h0, inte});
    chk("ctrl acc", 32'h0, {28'h0, acc});
    apb(1'b0, REG_IRQ, 32'h0);
    chk("irq regs", 32'h1dd0, rd);
    apb(1'b0, REG_TIMER, 32'h0);
    chk("timer regs", 32'h000d000d, rd);
    apb(1'b0, REG_CORE, 32'h0);
    chk("request flag", 32'h0, {31'h0, rd[15]});
    irq_req <= 1'b1;
    @(negedge pclk);
    chk("irq ack", 32'h1, {31'h0, irq_ack});
    @(posedge pclk);
    irq_req <= 1'b0;
    repeat (4) @(negedge pclk);
    chk("irq return pc", 32'he, {18'h0, rom_addr});
    chk("irq return acc", 32'h0, {28'h0, acc});
    $display("test ctrl_ops done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_branch_skip();
    t_regs();
    t_ctrl_ops();
    give_verdict();
  end
endmodule
